/* File: hw/ltc_consts.svh */
// Offsets, field positions, reset values and timing figures of the loop tuning block.
`ifndef LTC_CONSTS_SVH
`define LTC_CONSTS_SVH
// ==========================================================================
// Timing
`define LTC_CLK_NS 50
`define LTC_MS_NS 1000000
`define LTC_TUNE_MIN_MS 50
`define LTC_TUNE_MAX_MS 200
`define LTC_TUNE_MS 100
`define LTC_SEC_MS 1000
`define LTC_MIN_MS 60000
// ==========================================================================
// Register byte offsets
`define LTC_A_CTRL 8'h00
`define LTC_A_GAIN 8'h04
`define LTC_A_TAPA 8'h08
`define LTC_A_TAPB 8'h0C
`define LTC_A_TAPC 8'h10
`define LTC_A_NLR 8'h14
`define LTC_A_VOUT 8'h18
`define LTC_A_STAT 8'h1C
`define LTC_A_VLIM 8'h20
// ==========================================================================
// Control fields
`define LTC_F_MODE 0
`define LTC_F_ONCE 2
`define LTC_F_TRIG 3
`define LTC_F_STORE 4
// ==========================================================================
// Reset values and scaling
`define LTC_GAIN_MIN 7'h0A
`define LTC_GAIN_MAX 7'h64
`define LTC_GAIN_RST 7'h32
`define LTC_SAFE_COEF 72'h400000C00000400000
`define LTC_USER_RST_COEF 72'h200000E00000200000
`define LTC_NLR_RST 32'h00000101
`define LTC_PCT_RECIP 13'sh051F
`define LTC_PCT_SHIFT 17
`define LTC_VMAX_NUM 16'h000B
`define LTC_VMAX_DEN 16'h000A
`define LTC_STRAP_SHORT 5'h1C
`define LTC_STRAP_OPEN 5'h1D
`define LTC_STRAP_HIGH 5'h1E
`define LTC_RESP_OKAY 2'h0
`define LTC_RESP_SLVERR 2'h2
`endif

/* File: hw/ltc_pkg.sv */
// Types shared by the loop tuning configuration block.
package ltc_pkg;
  typedef enum logic [1:0] {MODE_OFF, MODE_ONCE, MODE_SEC, MODE_MIN} tune_mode_t;
  typedef enum logic [1:0] {ST_INIT, ST_IDLE, ST_TUNE} ctl_state_t;
  typedef struct packed {
    logic [23:0] a;
    logic [23:0] b;
    logic [23:0] c;
  } coef_t;
  typedef struct packed {
    logic [15:0] target_mv;
    logic [15:0] limit_mv;
  } vout_t;
endpackage : ltc_pkg

/* File: hw/loop_tuning_config_control.sv */
// Adaptive loop tuning, coefficient store handling and set-point strap decode.
//
// Our own choices: the AXI4-Lite interface to the registers and the placing of the registers.
`include "ltc_consts.svh"

module loop_tuning_config_control
  import ltc_pkg::*;
#(
  parameter int MS_CYCLES = `LTC_MS_NS / `LTC_CLK_NS,
  parameter int TUNE_MS = `LTC_TUNE_MS,
  parameter int SEC_MS = `LTC_SEC_MS,
  parameter int MIN_MS = `LTC_MIN_MS
)
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [4:0] setpoint_strap_pin,
  input wire logic output_enable,
  input wire logic ramp_done,
  input wire coef_t measured_coefs,
  output coef_t compensator_coefficients,
  output logic [31:0] nonlinear_transient_boost,
  output vout_t vout_setting,
  output logic tune_busy
);

  // ==========================================================================
  // Helpers
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++)
    begin
      if (strb[i])
        r[i*8 +: 8] = nw[i*8 +: 8];
    end
    return r;
  endfunction : merge

  // Millivolts for each strap code; an unknown code falls to the lowest level.
  function automatic logic [15:0] strap_mv(input logic [4:0] code);
    logic [15:0] mv;
    case (code)
      5'h00: mv = 16'd600;   5'h01: mv = 16'd650;   5'h02: mv = 16'd700;
      5'h03: mv = 16'd750;   5'h04: mv = 16'd800;   5'h05: mv = 16'd850;
      5'h06: mv = 16'd900;   5'h07: mv = 16'd950;   5'h08: mv = 16'd1000;
      5'h09: mv = 16'd1050;  5'h0A: mv = 16'd1100;  5'h0B: mv = 16'd1150;
      5'h0C: mv = 16'd1200;  5'h0D: mv = 16'd1250;  5'h0E: mv = 16'd1300;
      5'h0F: mv = 16'd1400;  5'h10: mv = 16'd1500;  5'h11: mv = 16'd1600;
      5'h12: mv = 16'd1700;  5'h13: mv = 16'd1800;  5'h14: mv = 16'd1900;
      5'h15: mv = 16'd2000;  5'h16: mv = 16'd2100;  5'h17: mv = 16'd2200;
      5'h18: mv = 16'd2300;  5'h19: mv = 16'd2500;  5'h1A: mv = 16'd3000;
      5'h1B: mv = 16'd3300;
      `LTC_STRAP_SHORT: mv = 16'd600;
      `LTC_STRAP_OPEN: mv = 16'd1200;
      `LTC_STRAP_HIGH: mv = 16'd2500;
      default: mv = 16'd600;
    endcase
    return mv;
  endfunction : strap_mv

  // ==========================================================================
  // State
  ctl_state_t state_reg;
  tune_mode_t mode_reg;
  logic once_reg, held_valid_reg, ramp_q_reg, tick_reg;
  logic [6:0] gain_reg;
  coef_t work_reg, user_coef_reg, held_reg, work_next;
  logic [31:0] nlr_reg, user_nlr_reg;
  logic [15:0] vout_reg, vmax_reg, run_ms_reg, per_cnt_reg;
  logic [4:0] strap_reg;
  logic [31:0] ms_cnt_reg;
  logic [31:0] aw_addr_reg, w_data_reg;
  logic [3:0] w_strb_reg;
  logic aw_have_reg, w_have_reg;

  // ==========================================================================
  // Write decode
  wire wr_fire = aw_have_reg & w_have_reg & ~s_axi_bvalid;
  wire aw_page = aw_addr_reg[31:8] == 24'h000000;
  wire [7:0] aw_off = aw_addr_reg[7:0];
  wire wr_ctrl = wr_fire & aw_page & (aw_off == `LTC_A_CTRL);
  wire wr_gain = wr_fire & aw_page & (aw_off == `LTC_A_GAIN);
  wire wr_tapa = wr_fire & aw_page & (aw_off == `LTC_A_TAPA);
  wire wr_tapb = wr_fire & aw_page & (aw_off == `LTC_A_TAPB);
  wire wr_tapc = wr_fire & aw_page & (aw_off == `LTC_A_TAPC);
  wire wr_nlr = wr_fire & aw_page & (aw_off == `LTC_A_NLR);
  wire wr_vout = wr_fire & aw_page & (aw_off == `LTC_A_VOUT);
  wire wr_ro = aw_page & ((aw_off == `LTC_A_STAT) | (aw_off == `LTC_A_VLIM));
  wire wr_ok = wr_ctrl | wr_gain | wr_tapa | wr_tapb | wr_tapc | wr_nlr | wr_vout | wr_ro;

  wire [31:0] ctrl_view = {27'h0000000, 2'h0, once_reg, mode_reg};
  wire [31:0] ctrl_w = merge(ctrl_view, w_data_reg, w_strb_reg);
  wire [31:0] gain_w = merge({25'h0000000, gain_reg}, w_data_reg, w_strb_reg);
  wire [31:0] tapa_w = merge({8'h00, work_reg.a}, w_data_reg, w_strb_reg);
  wire [31:0] tapb_w = merge({8'h00, work_reg.b}, w_data_reg, w_strb_reg);
  wire [31:0] tapc_w = merge({8'h00, work_reg.c}, w_data_reg, w_strb_reg);
  wire [31:0] nlr_w = merge(nlr_reg, w_data_reg, w_strb_reg);
  wire [31:0] vout_w = merge({16'h0000, vout_reg}, w_data_reg, w_strb_reg);

  wire tune_mode_t new_mode = tune_mode_t'(ctrl_w[`LTC_F_MODE +: 2]);
  wire off_to_on = wr_ctrl & (mode_reg == MODE_OFF) & (new_mode != MODE_OFF);
  wire on_to_off = wr_ctrl & (mode_reg != MODE_OFF) & (new_mode == MODE_OFF);
  wire trig_w = wr_ctrl & ctrl_w[`LTC_F_TRIG];
  wire store_w = wr_ctrl & ctrl_w[`LTC_F_STORE];

  // Gain outside 10..100 percent is pulled to the nearest end.
  wire [6:0] gain_in = (gain_w[31:7] != 25'h0000000) ? `LTC_GAIN_MAX : gain_w[6:0];
  wire [6:0] gain_clamped = (gain_in < `LTC_GAIN_MIN) ? `LTC_GAIN_MIN :
                            (gain_in > `LTC_GAIN_MAX) ? `LTC_GAIN_MAX : gain_in;
  wire [15:0] vout_clamped = (vout_w[31:16] != 16'h0000) ? vmax_reg :
                             (vout_w[15:0] > vmax_reg) ? vmax_reg : vout_w[15:0];

  // ==========================================================================
  // Tuning sequencer
  wire init_w = state_reg == ST_INIT;
  wire idle_w = state_reg == ST_IDLE;
  wire in_tune = state_reg == ST_TUNE;
  wire ramp_evt = ramp_done & ~ramp_q_reg & output_enable;
  wire periodic = (mode_reg == MODE_SEC) | (mode_reg == MODE_MIN);
  wire [15:0] per_lim = (mode_reg == MODE_MIN) ? 16'(MIN_MS - 1) : 16'(SEC_MS - 1);
  wire use_held = once_reg & held_valid_reg;
  wire auto_w = ramp_evt & (mode_reg != MODE_OFF) & ~use_held;
  wire period_w = periodic & (per_cnt_reg == per_lim);
  wire start_w = idle_w & output_enable & ~on_to_off & (auto_w | period_w | trig_w);
  wire reuse_w = idle_w & ramp_evt & (mode_reg != MODE_OFF) & use_held & ~trig_w
                 & ~on_to_off & ~period_w;
  wire abort_w = in_tune & (~output_enable | on_to_off);
  wire done_w = in_tune & ~abort_w & tick_reg & (run_ms_reg == 16'(TUNE_MS - 1));

  // Gain scaling: tap * gain * (1311 / 2^17), which stays just over tap * gain / 100.
  coef_t scaled;
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++)
    begin : g_scale
      wire signed [23:0] tap = measured_coefs[gi*24 +: 24];
      wire signed [44:0] prod = tap * $signed({1'b0, gain_reg}) * `LTC_PCT_RECIP;
      assign scaled[gi*24 +: 24] = prod[`LTC_PCT_SHIFT +: 24];
    end
  endgenerate

  // Working taps: reset and the two mode changes take priority over a finished run.
  wire coef_t safe_coef = coef_t'(`LTC_SAFE_COEF);
  wire coef_t host_coef = wr_tapa ? coef_t'({tapa_w[23:0], work_reg.b, work_reg.c}) :
                          wr_tapb ? coef_t'({work_reg.a, tapb_w[23:0], work_reg.c}) :
                          coef_t'({work_reg.a, work_reg.b, tapc_w[23:0]});
  assign work_next = init_w ? ((mode_reg == MODE_OFF) ? user_coef_reg : safe_coef) :
                     on_to_off ? user_coef_reg :
                     off_to_on ? safe_coef :
                     done_w ? scaled :
                     reuse_w ? held_reg :
                     (wr_tapa | wr_tapb | wr_tapc) ? host_coef : work_reg;

  // ==========================================================================
  // Clocked state
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ms_cnt_reg <= 32'h00000000;
      tick_reg <= 1'b0;
    end
    else
    begin
      tick_reg <= ms_cnt_reg == 32'(MS_CYCLES - 1);
      ms_cnt_reg <= (ms_cnt_reg == 32'(MS_CYCLES - 1)) ? 32'h00000000 : ms_cnt_reg + 32'h1;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state_reg <= ST_INIT;
      tune_busy <= 1'b0;
      run_ms_reg <= 16'h0000;
      per_cnt_reg <= 16'h0000;
      ramp_q_reg <= 1'b0;
    end
    else
    begin
      ramp_q_reg <= ramp_done;
      case (state_reg)
        ST_INIT: state_reg <= ST_IDLE;
        ST_IDLE: state_reg <= start_w ? ST_TUNE : ST_IDLE;
        ST_TUNE: state_reg <= (abort_w | done_w) ? ST_IDLE : ST_TUNE;
        default: state_reg <= ST_IDLE;
      endcase
      tune_busy <= (idle_w & start_w) | (in_tune & ~abort_w & ~done_w);
      if (start_w)
        run_ms_reg <= 16'h0000;
      else if (in_tune & tick_reg)
        run_ms_reg <= run_ms_reg + 16'h1;
      if (start_w | ~output_enable | ~periodic)
        per_cnt_reg <= 16'h0000;
      else if (tick_reg & (per_cnt_reg != per_lim))
        per_cnt_reg <= per_cnt_reg + 16'h1;
    end
  end

  // The user store models non-volatile memory; a reset stands for power application.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      work_reg <= coef_t'(`LTC_SAFE_COEF);
      user_coef_reg <= coef_t'(`LTC_USER_RST_COEF);
      user_nlr_reg <= `LTC_NLR_RST;
      held_reg <= coef_t'(`LTC_SAFE_COEF);
      held_valid_reg <= 1'b0;
    end
    else
    begin
      work_reg <= work_next;
      if (store_w)
      begin
        user_coef_reg <= work_reg;
        user_nlr_reg <= nlr_reg;
      end
      if (done_w)
      begin
        held_reg <= scaled;
        held_valid_reg <= 1'b1;
      end
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      mode_reg <= MODE_ONCE;
      once_reg <= 1'b0;
      gain_reg <= `LTC_GAIN_RST;
      nlr_reg <= `LTC_NLR_RST;
    end
    else
    begin
      if (init_w)
        nlr_reg <= user_nlr_reg;
      else if (wr_nlr)
        nlr_reg <= nlr_w;
      if (wr_ctrl)
      begin
        mode_reg <= new_mode;
        once_reg <= ctrl_w[`LTC_F_ONCE];
      end
      if (wr_gain)
        gain_reg <= gain_clamped;
    end
  end

  // Strap is captured once after reset and never looked at again.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      strap_reg <= 5'h00;
      vout_reg <= 16'h0000;
      vmax_reg <= 16'h0000;
    end
    else if (init_w)
    begin
      strap_reg <= setpoint_strap_pin;
      vout_reg <= strap_mv(setpoint_strap_pin);
      vmax_reg <= strap_mv(setpoint_strap_pin) * `LTC_VMAX_NUM / `LTC_VMAX_DEN;
    end
    else if (wr_vout)
      vout_reg <= vout_clamped;
  end

  assign compensator_coefficients = work_reg;
  assign nonlinear_transient_boost = nlr_reg;
  assign vout_setting = '{target_mv: vout_reg, limit_mv: vmax_reg};

  // ==========================================================================
  // AXI4-Lite write channel
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `LTC_RESP_OKAY;
      aw_have_reg <= 1'b0;
      w_have_reg <= 1'b0;
      aw_addr_reg <= 32'h00000000;
      w_data_reg <= 32'h00000000;
      w_strb_reg <= 4'h0;
    end
    else
    begin
      if (s_axi_awvalid & s_axi_awready)
      begin
        aw_have_reg <= 1'b1;
        aw_addr_reg <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      else if (~aw_have_reg & ~s_axi_bvalid)
        s_axi_awready <= 1'b1;
      if (s_axi_wvalid & s_axi_wready)
      begin
        w_have_reg <= 1'b1;
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      else if (~w_have_reg & ~s_axi_bvalid)
        s_axi_wready <= 1'b1;
      if (wr_fire)
      begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_ok ? `LTC_RESP_OKAY : `LTC_RESP_SLVERR;
      end
      else if (s_axi_bvalid & s_axi_bready)
      begin
        s_axi_bvalid <= 1'b0;
        aw_have_reg <= 1'b0;
        w_have_reg <= 1'b0;
      end
    end
  end

  // ==========================================================================
  // AXI4-Lite read channel
  wire ar_page = s_axi_araddr[31:8] == 24'h000000;
  wire [7:0] ar_off = s_axi_araddr[7:0];
  wire [31:0] stat_view = {24'h000000, 1'b0, strap_reg, held_valid_reg, tune_busy};
  wire [31:0] rd_word = (ar_off == `LTC_A_CTRL) ? ctrl_view :
                        (ar_off == `LTC_A_GAIN) ? {25'h0000000, gain_reg} :
                        (ar_off == `LTC_A_TAPA) ? {8'h00, work_reg.a} :
                        (ar_off == `LTC_A_TAPB) ? {8'h00, work_reg.b} :
                        (ar_off == `LTC_A_TAPC) ? {8'h00, work_reg.c} :
                        (ar_off == `LTC_A_NLR) ? nlr_reg :
                        (ar_off == `LTC_A_VOUT) ? {16'h0000, vout_reg} :
                        (ar_off == `LTC_A_STAT) ? stat_view : {16'h0000, vmax_reg};
  wire rd_hit = ar_page & ((ar_off <= `LTC_A_VLIM) & (ar_off[1:0] == 2'h0));

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `LTC_RESP_OKAY;
    end
    else if (s_axi_arvalid & s_axi_arready)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_hit ? rd_word : 32'h00000000;
      s_axi_rresp <= rd_hit ? `LTC_RESP_OKAY : `LTC_RESP_SLVERR;
    end
    else if (s_axi_rvalid & s_axi_rready)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
    else if (~s_axi_rvalid)
      s_axi_arready <= 1'b1;
  end

  // ==========================================================================
  // Checks
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  chk_ramp_start: assert property (idle_w && auto_w && output_enable && !on_to_off
    |=> tune_busy) else $error("ramp end did not start a tuning run");
  chk_run_length: assert property (in_tune |-> run_ms_reg <= 16'(TUNE_MS - 1))
    else $error("tuning run ended at wrong length");
  chk_manual_trig: assert property (idle_w && trig_w && output_enable && !on_to_off
    |=> tune_busy) else $error("manual trigger ignored");
  chk_gain_range: assert property (gain_reg >= `LTC_GAIN_MIN && gain_reg <= `LTC_GAIN_MAX)
    else $error("gain out of range");
  chk_store_all: assert property (store_w |=> user_coef_reg == $past(work_reg))
    else $error("store did not copy working taps");
  chk_tune_on_safe: assert property (off_to_on |=> work_reg == safe_coef)
    else $error("safe taps not loaded when tuning enabled");
  chk_tune_off_user: assert property (on_to_off |=> work_reg == $past(user_coef_reg))
    else $error("user taps not reloaded when tuning disabled");
  chk_reuse_held: assert property (reuse_w |=> work_reg == $past(held_reg) && !tune_busy)
    else $error("held taps not reused");
  chk_strap_frozen: assert property (!init_w && !$past(init_w) |-> $stable(vmax_reg))
    else $error("limit changed after start-up");
  chk_vout_clamp: assert property (!init_w && !$past(init_w) |-> vout_reg <= vmax_reg)
    else $error("set-point above limit");
  chk_abort_keep: assert property (in_tune && !output_enable && !wr_fire
    |=> !tune_busy ##0 $stable(work_reg)) else $error("abandoned run changed taps");

endmodule : loop_tuning_config_control

/* File: dv/power_stage_model.sv */
// Behavioural power stage that ramps the output and hands over a tuning result.
module power_stage_model
  import ltc_pkg::*;
(
  input wire logic aclk,
  input wire logic output_enable,
  input wire logic [7:0] ramp_cyc,
  input wire coef_t result,
  output logic ramp_done,
  output coef_t measured_coefs
);
  timeunit 1ns;
  timeprecision 1ns;
  int cnt = 0;
  // ==========================================================================
  // Ramp
  always @(posedge aclk)
    cnt <= output_enable ? cnt + 1 : 0;
  assign ramp_done = output_enable && cnt > int'(ramp_cyc);
  // The result only changes while the output is off, so the input is steady for a run.
  assign measured_coefs = result;
endmodule : power_stage_model

/* File: dv/loop_tuning_config_control_bench.sv */
// Self-checking bench of the loop tuning configuration block.
`include "ltc_consts.svh"
module loop_tuning_config_control_bench
  import ltc_pkg::*;
  ;
  timeunit 1ns;
  timeprecision 1ns;
  logic aclk = '0, aresetn = '0, output_enable = '0, ramp_done, tune_busy;
  logic [31:0] s_axi_awaddr = '0, s_axi_wdata = '0, s_axi_araddr = '0, s_axi_rdata;
  logic [31:0] nonlinear_transient_boost;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = '0, s_axi_wvalid = '0, s_axi_bready = '0, s_axi_arvalid = '0;
  logic s_axi_rready = '0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [4:0] setpoint_strap_pin = '0;
  logic [7:0] ramp_cyc = 8'h01;
  coef_t measured_coefs, compensator_coefficients, result = '0;
  vout_t vout_setting;
  int mismatches = 0, num_checks = 0, cycles = 0;
  int gw[5] = '{5, 200, 127, 10, 100}, ge[5] = '{10, 100, 100, 10, 100};
  int lvl[28] = '{600, 650, 700, 750, 800, 850, 900, 950, 1000, 1050, 1100, 1150, 1200, 1250,
    1300, 1400, 1500, 1600, 1700, 1800, 1900, 2000, 2100, 2200, 2300, 2500, 3000, 3300};
  logic [71:0] rq[$];
  loop_tuning_config_control #(.MS_CYCLES(4), .TUNE_MS(3), .SEC_MS(10), .MIN_MS(20)) dut (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .setpoint_strap_pin, .output_enable, .ramp_done, .measured_coefs, .compensator_coefficients,
    .nonlinear_transient_boost, .vout_setting, .tune_busy);
  power_stage_model psm (.aclk, .output_enable, .ramp_cyc, .result, .ramp_done, .measured_coefs);
  always #25 aclk = ~aclk;
  // ==========================================================================
  // Checking and closing
  task automatic chk(input string n, input logic [71:0] e, input logic [71:0] g);
    num_checks++;
    if (g !== e)
    begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : wrap_up
  always @(posedge aclk)
  begin
    cycles <= cycles + 1;
    if (s_axi_rvalid && s_axi_rready)
      chk("rdata", rq.pop_front(), {38'h0, s_axi_rresp, s_axi_rdata});
    if (cycles == 5000)
    begin
      mismatches++;
      wrap_up();
    end
  end
  // ==========================================================================
  // Bus and helper tasks
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s = 4'hF,
    input logic [1:0] er = `LTC_RESP_OKAY);
    @(posedge aclk);
    s_axi_awaddr <= {24'h0, a};
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wready)
        s_axi_wvalid <= 1'b0;
    end
    while (!s_axi_bvalid);
    chk("bresp", {70'h0, er}, {70'h0, s_axi_bresp});
    s_axi_bready <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = 2'h0);
    @(posedge aclk);
    rq.push_back({38'h0, er, d});
    s_axi_araddr <= {24'h0, a};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axi_arready)
        s_axi_arvalid <= 1'b0;
    end
    while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
  endtask : rd
  task automatic wt(input logic v, output int n);
    n = 0;
    while (tune_busy !== v && n < 300)
    begin
      @(posedge aclk);
      n++;
    end
    if (n == 300)
      chk("busy wait", 72'h1, 72'h0);
  endtask : wt
  task automatic taps(input coef_t e);
    rd(`LTC_A_TAPA, {8'h0, e.a});
    rd(`LTC_A_TAPB, {8'h0, e.b});
    rd(`LTC_A_TAPC, {8'h0, e.c});
    chk("taps", e, compensator_coefficients);
  endtask : taps
  // Fields stay below 2^20 so the scaled product never depends on sign handling.
  function automatic coef_t rnd();
    return {24'($urandom % 1048576), 24'($urandom % 1048576), 24'($urandom % 1048576)};
  endfunction : rnd
  function automatic coef_t scl(input coef_t m, input int g);
    return {24'((longint'(m.a) * g * 1311) >>> 17), 24'((longint'(m.b) * g * 1311) >>> 17),
      24'((longint'(m.c) * g * 1311) >>> 17)};
  endfunction : scl
  task automatic boot(input logic [4:0] c);
    @(posedge aclk);
    aresetn <= 1'b0;
    output_enable <= 1'b0;
    setpoint_strap_pin <= c;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    setpoint_strap_pin <= ~c;
  endtask : boot
  // ==========================================================================
  // Scenarios
  initial
  begin
    coef_t u;
    coef_t v;
    int e, n, k, g;
    int r[4];
    logic b;
    void'($urandom(88));
    for (int i = 0; i < 5; i++)
    begin
      g = i ? 26 + i : $urandom % 28;
      boot(5'(g));
      e = g < 28 ? lvl[g] : g == 29 ? 1200 : g == 30 ? 2500 : 600;
      rd(`LTC_A_VOUT, 32'(e));
      rd(`LTC_A_VLIM, 32'(e * 11 / 10));
      chk("vout", 72'({16'(e), 16'(e * 11 / 10)}), 72'(vout_setting));
    end
    rd(`LTC_A_CTRL, 32'h1);
    rd(`LTC_A_GAIN, 32'h32);
    rd(`LTC_A_NLR, `LTC_NLR_RST);
    chk("safe", `LTC_SAFE_COEF, compensator_coefficients);
    wr(`LTC_A_VOUT, 32'hFFFF);
    rd(`LTC_A_VOUT, 32'(e * 11 / 10));
    wr(`LTC_A_NLR, 32'hAABBCCDD, 4'h1);
    rd(`LTC_A_NLR, 32'h1DD);
    chk("nlr out", 72'h1DD, 72'(nonlinear_transient_boost));
    wr(8'h40, '0, 4'hF, `LTC_RESP_SLVERR);
    rd(8'h40, '0, `LTC_RESP_SLVERR);
    for (int i = 0; i < 5; i++)
    begin
      wr(`LTC_A_GAIN, 32'(gw[i]));
      rd(`LTC_A_GAIN, 32'(ge[i]));
    end
    g = 10 + $urandom % 91;
    wr(`LTC_A_GAIN, 32'(g));
    u = rnd();
    result <= u;
    output_enable <= 1'b1;
    wt(1'b1, n);
    wt(1'b0, n);
    chk("run length", 72'(n > 8 && n < 16), 72'h1);
    taps(scl(u, g));
    wr(`LTC_A_CTRL, 32'h9);
    wt(1'b1, n);
    output_enable <= 1'b0;
    wt(1'b0, n);
    taps(scl(u, g));
    wr(`LTC_A_CTRL, 32'h0);
    taps(`LTC_USER_RST_COEF);
    v = 72'h7CB941FDC3417CCD99;
    for (int i = 0; i < 3; i++)
      wr(8'(8 + 4 * i), {8'h0, 24'(v >> (48 - 24 * i))});
    wr(`LTC_A_CTRL, 32'h10);
    wr(`LTC_A_CTRL, 32'h1);
    taps(`LTC_SAFE_COEF);
    wr(`LTC_A_CTRL, 32'h0);
    taps(v);
    output_enable <= 1'b1;
    for (int m = 2; m < 4; m++)
    begin
      wr(`LTC_A_CTRL, 32'(m));
      k = 0;
      repeat (170)
      begin
        b = tune_busy;
        @(posedge aclk);
        k += int'(tune_busy && !b);
      end
      r[m] = k;
    end
    chk("periodic", 72'(r[2] > r[3] && r[3] > 0), 72'h1);
    boot(5'h1C);
    wr(`LTC_A_CTRL, 32'h5);
    result <= u;
    output_enable <= 1'b1;
    wt(1'b1, n);
    wt(1'b0, n);
    taps(scl(u, 50));
    output_enable <= 1'b0;
    result <= rnd();
    ramp_cyc <= 8'h19;
    repeat (3) @(posedge aclk);
    output_enable <= 1'b1;
    k = 0;
    repeat (60)
    begin
      @(posedge aclk);
      k += int'(tune_busy);
    end
    chk("reuse", 72'(k), 72'h0);
    taps(scl(u, 50));
    boot(5'h1C);
    wr(`LTC_A_CTRL, 32'h5);
    output_enable <= 1'b1;
    wt(1'b1, n);
    wt(1'b0, n);
    taps(scl(result, 50));
    wrap_up();
  end
endmodule : loop_tuning_config_control_bench
